// >>> rtl/cib_defs.vh
// Constants for the two-wire I/O buffer port of the security coprocessor.
// Assumes a 100 MHz core clock; included by rtl/cib_port.v.
`ifndef CIB_DEFS_VH
`define CIB_DEFS_VH

// Core clock period in ns
`define CIB_CLK_NS 10
// I/O buffer size in bytes
`define CIB_BUF_BYTES 7'h47
// Largest output group in bytes
`define CIB_GRP_MAX 7'h23
// Length of a status or error group
`define CIB_GRP_MIN 8'h04
// Status byte offered after power-up or sleep
`define CIB_STAT_WAKE 8'h11
// Byte driven when nothing valid is left
`define CIB_FILL 8'hFF
// Word address codes
`define CIB_WA_RESET 8'h00
`define CIB_WA_SLEEP 8'h01
`define CIB_WA_IDLE 8'h02
`define CIB_WA_CMD 8'h03
// Bus-stuck timeout, least time, in microseconds
`define CIB_TMO_MIN_US 25
// Bus-stuck timeout in core cycles, rounded up
`define CIB_TMO_CYCLES ((`CIB_TMO_MIN_US * 1000 + `CIB_CLK_NS - 1) / `CIB_CLK_NS)
// Awake watchdog interval in milliseconds
`define CIB_WDOG_MS 1300
// Watchdog interval in core cycles, rounded down
`define CIB_WDOG_CYCLES ((`CIB_WDOG_MS * 1000000) / `CIB_CLK_NS)
// Default checksum bytes of the wake status group
`define CIB_STAT_CRC_LO 8'h00
`define CIB_STAT_CRC_HI 8'h00

`endif

// >>> rtl/cib_sync.v
// Two-flop synchroniser for bus pins entering the core clock domain.
// Assumes the inputs are asynchronous levels; only the second stage reads the first.
`timescale 1ns/1ns

module cib_sync #(
   parameter W = 1
) (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Asynchronous levels in, synchronised levels out
   input wire [W-1:0] d,
   output reg [W-1:0] q
);

   reg [W-1:0] meta; // First stage, read only by q

   // Pins idle high, so both stages reset high
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         meta <= {W{1'b1}};
         q <= {W{1'b1}};
      end else begin
         meta <= d;
         q <= meta;
      end
   end

endmodule // cib_sync

// >>> rtl/cib_port.v
// Two-wire slave port with the shared command/result I/O buffer.
// Assumes SCL, SDA and WAKE are asynchronous pins; the command engine runs on CLOCK.
`timescale 1ns/1ns
`include "cib_defs.vh"

module cib_port #(
   parameter WDOG_CYCLES = `CIB_WDOG_CYCLES,
   parameter TMO_CYCLES = `CIB_TMO_CYCLES,
   parameter [7:0] STAT_CRC_LO = `CIB_STAT_CRC_LO,
   parameter [7:0] STAT_CRC_HI = `CIB_STAT_CRC_HI
) (
   // Clock and reset
   input wire CLOCK,
   input wire RST,
   // Two-wire bus pins
   input wire SCL_IN,
   input wire SDA_IN,
   output reg SDA_OUT,
   output reg SDA_OE,
   // Wake token detected on the bus
   input wire WAKE,
   // Configured bus address, bits 7..1
   input wire [6:0] DEV_ADDR,
   // Command engine: start and completion
   output reg EXEC_START,
   input wire EXEC_DONE,
   input wire [6:0] RES_LEN,
   // Command engine: result writes into the buffer
   input wire RES_WE,
   input wire [6:0] RES_ADDR,
   input wire [7:0] RES_DATA,
   // Command engine: buffer read port
   input wire [6:0] BUF_ADDR,
   output reg [7:0] BUF_RDATA,
   // Device state
   output reg ASLEEP,
   output reg IDLE,
   output reg BUSY
);

   // Bus engine states, one-hot
   localparam [6:0] ST_WAIT = 7'h01;
   localparam [6:0] ST_ADDR = 7'h02;
   localparam [6:0] ST_ACK = 7'h04;
   localparam [6:0] ST_WORD = 7'h08;
   localparam [6:0] ST_WDATA = 7'h10;
   localparam [6:0] ST_READ = 7'h20;
   localparam [6:0] ST_RACK = 7'h40;

   wire [2:0] pins; // Synchronised SCL, SDA, WAKE
   reg scl_d; // Previous synchronised SCL
   reg sda_d; // Previous synchronised SDA
   reg wake_d; // Previous synchronised WAKE
   reg [6:0] st; // Bus engine state
   reg [6:0] ack_next; // State after the ack bit, WAIT on a refused address or a master NACK of a read byte
   reg [3:0] bitcnt; // Bits moved in the current byte
   reg [7:0] shreg; // Receive shifter
   reg [7:0] txreg; // Byte being sent
   reg is_read; // Transfer direction of this transaction
   reg got_word; // Word address seen in this write
   reg [7:0] word; // Last word address
   reg [7:0] iobuf [0:70]; // Shared I/O buffer
   reg [6:0] cnt; // Address counter
   reg [6:0] wr_count; // Command bytes received so far
   reg [7:0] size; // Size byte of the command
   reg [6:0] out_len; // Valid output bytes
   reg rd_done; // Output bytes read since last write
   reg [31:0] wdog; // Awake time counter
   reg [31:0] tmo; // SCL low time counter
   integer i;

   wire scl = pins[2];
   wire sda = pins[1];
   wire wake = pins[0];
   wire scl_rise = scl & ~scl_d;
   wire scl_fall = ~scl & scl_d;
   wire start_c = scl & scl_d & sda_d & ~sda;
   wire stop_c = scl & scl_d & ~sda_d & sda;
   wire awake = ~ASLEEP & ~IDLE;
   wire partial = (wr_count != 7'h00) && ({1'b0, wr_count} < size);
   wire complete = (wr_count != 7'h00) && ({1'b0, wr_count} >= size);
   wire addr_hit = (shreg[7:1] == DEV_ADDR);
   wire take_byte = (word == `CIB_WA_CMD) && (cnt < `CIB_BUF_BYTES) &&
      ((wr_count == 7'h00) || ({1'b0, wr_count} < size));
   wire [7:0] rd_byte = fetch(partial, cnt, out_len, iobuf[cnt[6:0] % 71]);

   // Read data: all ones while a command is partial or past the end
   function [7:0] fetch;
      input part;
      input [6:0] c;
      input [6:0] len;
      input [7:0] b;
      begin
         fetch = (part || (c >= len)) ? `CIB_FILL : b;
      end
   endfunction

   // Counter advance for reads; holds at the end so it never wraps
   function [6:0] next_rd;
      input part;
      input [6:0] c;
      input [6:0] len;
      begin
         next_rd = (!part && (c < len)) ? c + 7'h01 : c;
      end
   endfunction

   // Pin synchroniser
   cib_sync #(
      .W(3)
   ) u_sync (
      .clk(CLOCK),
      .rst(RST),
      .d({SCL_IN, SDA_IN, WAKE}),
      .q(pins)
   );

   // Edge history of the synchronised pins
   always @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
         wake_d <= 1'b1;
      end else begin
         scl_d <= scl;
         sda_d <= sda;
         wake_d <= wake;
      end
   end

   // Engine read port, registered so the output is a flop
   always @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         BUF_RDATA <= 8'h00;
      end else begin
         BUF_RDATA <= (BUF_ADDR < `CIB_BUF_BYTES) ? iobuf[BUF_ADDR % 71] : `CIB_FILL;
      end
   end

   // Bus engine, buffer and device state; later statements take priority
   always @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         // Power-up: asleep, wake status group staged
         st <= ST_WAIT;
         ack_next <= ST_WAIT;
         bitcnt <= 4'h0;
         shreg <= 8'h00;
         txreg <= 8'h00;
         is_read <= 1'b0;
         got_word <= 1'b0;
         word <= 8'h00;
         cnt <= 7'h00;
         wr_count <= 7'h00;
         size <= 8'h00;
         out_len <= 7'h04;
         rd_done <= 1'b0;
         wdog <= 32'h0;
         tmo <= 32'h0;
         SDA_OUT <= 1'b0;
         SDA_OE <= 1'b0;
         EXEC_START <= 1'b0;
         ASLEEP <= 1'b1;
         IDLE <= 1'b0;
         BUSY <= 1'b0;
         for (i = 0; i < 71; i = i + 1) begin
            iobuf[i] <= 8'h00;
         end
         iobuf[0] <= `CIB_GRP_MIN;
         iobuf[1] <= `CIB_STAT_WAKE;
         iobuf[2] <= STAT_CRC_LO;
         iobuf[3] <= STAT_CRC_HI;
      end else begin
         EXEC_START <= 1'b0;
         // Bit level engine
         case (st)
            ST_ADDR, ST_WORD, ST_WDATA: begin
               if (scl_rise && bitcnt < 4'h8) begin
                  shreg <= {shreg[6:0], sda};
                  bitcnt <= bitcnt + 4'h1;
               end else if (scl_fall && bitcnt == 4'h8) begin
                  st <= ST_ACK;
                  if (st == ST_ADDR) begin
                     is_read <= shreg[0];
                     if (shreg[0]) begin
                        // Reads refused while busy or awaiting Stop
                        SDA_OE <= addr_hit && awake && !BUSY && !complete;
                        ack_next <= (addr_hit && awake && !BUSY && !complete) ?
                           ST_READ : ST_WAIT;
                     end else begin
                        SDA_OE <= addr_hit && awake && !BUSY;
                        ack_next <= (addr_hit && awake && !BUSY) ? ST_WORD : ST_WAIT;
                        if (addr_hit && awake && !BUSY && rd_done) begin
                           cnt <= 7'h00;
                           rd_done <= 1'b0;
                        end
                     end
                  end else if (st == ST_WORD) begin
                     word <= shreg;
                     got_word <= 1'b1;
                     SDA_OE <= 1'b1;
                     ack_next <= ST_WDATA;
                  end else begin
                     // Append to the input FIFO; overflow bytes refused
                     SDA_OE <= take_byte;
                     ack_next <= ST_WDATA;
                     if (take_byte) begin
                        iobuf[cnt % 71] <= shreg;
                        cnt <= cnt + 7'h01;
                        wr_count <= wr_count + 7'h01;
                        out_len <= 7'h00; // New input voids old results
                        if (wr_count == 7'h00) begin
                           size <= shreg;
                        end
                     end
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  bitcnt <= 4'h0;
                  st <= ack_next;
                  SDA_OE <= 1'b0;
                  if (ack_next == ST_READ) begin
                     // First read byte leaves on this same fall
                     txreg <= rd_byte;
                     SDA_OE <= ~rd_byte[7];
                     bitcnt <= 4'h1;
                     cnt <= next_rd(partial, cnt, out_len);
                     rd_done <= rd_done | ~partial;
                  end
               end
            end
            ST_READ: begin
               if (scl_fall) begin
                  if (bitcnt < 4'h8) begin
                     SDA_OE <= ~txreg[7 - bitcnt[2:0]];
                     bitcnt <= bitcnt + 4'h1;
                  end else begin
                     SDA_OE <= 1'b0; // Master owns the ack bit
                     st <= ST_RACK;
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  ack_next <= sda ? ST_WAIT : ST_READ;
               end else if (scl_fall) begin
                  st <= ack_next;
                  if (ack_next == ST_READ) begin
                     txreg <= rd_byte;
                     SDA_OE <= ~rd_byte[7];
                     bitcnt <= 4'h1;
                     cnt <= next_rd(partial, cnt, out_len);
                     rd_done <= rd_done | ~partial;
                  end
               end
            end
            default: begin
               st <= ST_WAIT;
            end
         endcase
         // Start and Stop, only heard while awake
         if (awake && start_c) begin
            st <= ST_ADDR;
            bitcnt <= 4'h0;
            SDA_OE <= 1'b0;
            got_word <= 1'b0;
            is_read <= 1'b0;
         end else if (awake && stop_c) begin
            st <= ST_WAIT;
            SDA_OE <= 1'b0;
            got_word <= 1'b0;
            if (got_word && !is_read) begin
               case (word)
                  `CIB_WA_RESET: begin
                     cnt <= 7'h00;
                     wr_count <= 7'h00;
                     size <= 8'h00;
                     rd_done <= 1'b0;
                  end
                  `CIB_WA_IDLE: begin
                     IDLE <= 1'b1;
                     st <= ST_WAIT;
                  end
                  `CIB_WA_CMD: begin
                     if (complete) begin
                        BUSY <= 1'b1;
                        EXEC_START <= 1'b1;
                     end
                  end
                  default: begin
                     wr_count <= wr_count; // Reserved codes do nothing
                  end
               endcase
            end
         end
         // Bus-stuck release; SCL high or idle bus clears the count
         if (st != ST_WAIT && !scl) begin
            tmo <= tmo + 32'h1;
            if (tmo >= TMO_CYCLES - 1) begin
               st <= ST_WAIT;
               SDA_OE <= 1'b0;
               tmo <= 32'h0;
            end
         end else begin
            tmo <= 32'h0;
         end
         // Engine writes results while busy
         if (BUSY && RES_WE && RES_ADDR < `CIB_BUF_BYTES) begin
            iobuf[RES_ADDR % 71] <= RES_DATA;
         end
         // Completion: group becomes readable from the start
         if (BUSY && EXEC_DONE) begin
            BUSY <= 1'b0;
            out_len <= (RES_LEN > `CIB_GRP_MAX) ? `CIB_GRP_MAX : RES_LEN;
            cnt <= 7'h00;
            wr_count <= 7'h00;
            size <= 8'h00;
            rd_done <= 1'b0;
         end
         // Wake token from sleep or idle restarts the watchdog
         if (wake & ~wake_d & (ASLEEP | IDLE)) begin
            ASLEEP <= 1'b0;
            IDLE <= 1'b0;
            wdog <= 32'h0;
         end else if (awake) begin
            wdog <= wdog + 32'h1;
         end
         // Sleep: by command or by watchdog; device state, buffer pointers and wake status group reset
         if ((awake && wdog >= WDOG_CYCLES - 1) || (awake && stop_c && got_word &&
            !is_read && word == `CIB_WA_SLEEP)) begin
            ASLEEP <= 1'b1;
            IDLE <= 1'b0;
            BUSY <= 1'b0;
            st <= ST_WAIT;
            SDA_OE <= 1'b0;
            cnt <= 7'h00;
            wr_count <= 7'h00;
            size <= 8'h00;
            rd_done <= 1'b0;
            out_len <= 7'h04;
            wdog <= 32'h0;
            iobuf[0] <= `CIB_GRP_MIN;
            iobuf[1] <= `CIB_STAT_WAKE;
            iobuf[2] <= STAT_CRC_LO;
            iobuf[3] <= STAT_CRC_HI;
         end
      end
   end

endmodule // cib_port

// >>> verif/cib_host.sv
// Two-wire bus master model: drives SCL and pulls SDA low.
// Assumes the bench resolves SDA as open drain with a pull-up.
`timescale 1ns/1ns

module cib_host (
   // Bus pins
   output logic scl,
   output logic sda_low,
   input wire sda
);
   logic [8:0] val; // Last byte seen, bit 8 set when the ninth bit was low (ack)
   event seen; // Fires after each ninth bit
   // Bus idles high, clock stands still between frames
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // Start or repeated start: SDA falls while SCL is high
   task automatic start();
      sda_low = 1'b0;
      #20 scl = 1'b1;
      #20 sda_low = 1'b1;
      #20 scl = 1'b0;
      #20;
   endtask
   // Stop: SDA rises while SCL is high
   task automatic stop();
      sda_low = 1'b1;
      #20 scl = 1'b1;
      #20 sda_low = 1'b0;
      #20;
   endtask
   // One 80 ns bit, data set mid-low, sampled mid-high
   task automatic bitx(input logic b, output logic r);
      sda_low = ~b;
      #20 scl = 1'b1;
      #20 r = sda;
      #20 scl = 1'b0;
      #20;
   endtask
   // Byte out MSB first, then the ninth bit
   task automatic xfer(input logic [7:0] d, input logic b9);
      logic [7:0] q;
      logic r;
      for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
      bitx(b9, r);
      val = {~r, q};
      -> seen;
   endtask
   // Channel reset: start, nine released clocks, start, stop
   task automatic resync();
      logic r;
      start();
      repeat (9) bitx(1'b1, r);
      start();
      stop();
   endtask
endmodule // cib_host

// >>> verif/cib_port_asserts.sv
// Checker for the two-wire port, watching only its pins.
// Assumes it is bound to cib_port with the same counts.
`timescale 1ns/1ns

module cib_port_chk #(
   parameter WDOG_CYCLES = 2000,
   parameter TMO_CYCLES = 200
) (
   // Pins of the port under watch
   input wire CLOCK,
   input wire RST,
   input wire SCL_IN,
   input wire SDA_OE,
   input wire WAKE,
   input wire EXEC_START,
   input wire EXEC_DONE,
   input wire [6:0] BUF_ADDR,
   input wire [7:0] BUF_RDATA,
   input wire ASLEEP,
   input wire IDLE,
   input wire BUSY
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RST);
   int lowc; // SCL low run length, saturating
   int awk; // Awake cycles since the last sleep or idle
   // Run-length counters; slack covers the pin synchronisers
   always @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         lowc <= 0;
         awk <= 0;
      end else begin
         lowc <= SCL_IN ? 0 : (lowc < 100000 ? lowc + 1 : lowc);
         awk <= (ASLEEP || IDLE) ? 0 : awk + 1;
      end
   end
   AST_TMO_RELEASE: assert property (lowc > TMO_CYCLES + 6 |-> !SDA_OE)
      else $error("SDA still driven after bus-stuck timeout");
   AST_WDOG_SLEEP: assert property (awk <= WDOG_CYCLES + 4)
      else $error("awake past the watchdog interval");
   AST_EXEC_ONE: assert property (EXEC_START |=> !EXEC_START)
      else $error("engine start longer than one cycle");
   AST_EXEC_BUSY: assert property (EXEC_START |-> ##[0:1] BUSY)
      else $error("engine start without busy");
   AST_DONE_FREE: assert property (BUSY && EXEC_DONE |=> !BUSY)
      else $error("busy kept after completion");
   AST_BUSY_HOLD: assert property (BUSY && !EXEC_DONE |=> BUSY || ASLEEP)
      else $error("busy dropped without completion");
   AST_SLEEP_QUIET: assert property (ASLEEP |-> !BUSY && !IDLE && !EXEC_START)
      else $error("activity while asleep");
   AST_WAKE_UP: assert property ($rose(WAKE) && (ASLEEP || IDLE) |-> ##[1:8] !(ASLEEP || IDLE))
      else $error("wake edge ignored");
   AST_IDLE_QUIET: assert property (IDLE && $past(IDLE) |-> !SDA_OE)
      else $error("SDA driven while idle");
   AST_BUF_FILL: assert property (BUF_ADDR >= 7'h47 |=> BUF_RDATA == 8'hFF)
      else $error("buffer read past end not all ones");
   cover property (EXEC_START);
   cover property (BUSY && EXEC_DONE);
   cover property ($rose(IDLE));
   cover property (lowc > TMO_CYCLES + 6);
endmodule // cib_port_chk

bind cib_port cib_port_chk #(.WDOG_CYCLES(WDOG_CYCLES), .TMO_CYCLES(TMO_CYCLES)) cib_port_chk_i (
   .CLOCK(CLOCK), .RST(RST), .SCL_IN(SCL_IN), .SDA_OE(SDA_OE), .WAKE(WAKE),
   .EXEC_START(EXEC_START), .EXEC_DONE(EXEC_DONE), .BUF_ADDR(BUF_ADDR),
   .BUF_RDATA(BUF_RDATA), .ASLEEP(ASLEEP), .IDLE(IDLE), .BUSY(BUSY));

// >>> verif/testbench.sv
// Self-checking bench for the two-wire port; plays the command engine too.
// Assumes cib_host as bus master and the checker bound in its own file.
`timescale 1ns/1ns

module testbench;
   localparam int WD = 30000; // Shortened watchdog so the run stays short
   localparam int TM = 200; // Shortened bus-stuck timeout
   localparam logic [7:0] CLO = 8'h5A; // Arbitrary checksum bytes
   localparam logic [7:0] CHI = 8'hC3;
   logic CLOCK, RST, WAKE, EXEC_DONE, RES_WE;
   logic [6:0] DEV_ADDR, RES_LEN, RES_ADDR, BUF_ADDR;
   logic [7:0] RES_DATA;
   logic [7:0] g [0:34]; // Group the host should read
   logic [7:0] c [0:70]; // Command bytes, c[0] is the size
   logic [17:0] exq [$]; // Expected {care, value} per bus byte
   logic [17:0] e;
   int bad_count, n_checks, cyc, nst, glen, m;
   wire SDA_OUT, SDA_OE, EXEC_START, ASLEEP, IDLE, BUSY, scl, sda_low;
   wire [7:0] BUF_RDATA;
   wire sda = ~(sda_low | SDA_OE); // Open drain with pull-up
   cib_host cib_host_i (.scl(scl), .sda_low(sda_low), .sda(sda));
   cib_port #(.WDOG_CYCLES(WD), .TMO_CYCLES(TM), .STAT_CRC_LO(CLO), .STAT_CRC_HI(CHI)) cib_port_i (
      .CLOCK(CLOCK), .RST(RST), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
      .WAKE(WAKE), .DEV_ADDR(DEV_ADDR), .EXEC_START(EXEC_START), .EXEC_DONE(EXEC_DONE),
      .RES_LEN(RES_LEN), .RES_WE(RES_WE), .RES_ADDR(RES_ADDR), .RES_DATA(RES_DATA),
      .BUF_ADDR(BUF_ADDR), .BUF_RDATA(BUF_RDATA), .ASLEEP(ASLEEP), .IDLE(IDLE), .BUSY(BUSY));
   initial begin
      CLOCK = 1'b0;
      forever #5 CLOCK = ~CLOCK;
   end
   // Hang limit and engine start count
   always @(posedge CLOCK) begin
      cyc++;
      if (EXEC_START === 1'b1) nst++;
      if (cyc == 90000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   // Oldest note against each byte the host saw; an empty queue always mismatches
   always @(cib_host_i.seen) begin
      n_checks++;
      e = exq.size() != 0 ? exq.pop_front() : {9'h1FF, ~cib_host_i.val};
      if (((cib_host_i.val ^ e[8:0]) & e[17:9]) !== 9'h000) begin
         bad_count++;
         $display("[FAIL] %0t bus byte %h expected %h", $time, cib_host_i.val, e[8:0]);
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tx(input logic [7:0] b, input logic ack);
      exq.push_back({9'h100, ack, 8'h00});
      cib_host_i.xfer(b, 1'b1);
   endtask
   task automatic rx(input logic [7:0] exp, input logic last);
      exq.push_back({9'h0FF, 1'b0, exp});
      cib_host_i.xfer(8'hFF, last);
   endtask
   // Read frame refused at the address
   task automatic rdn(input logic [6:0] a);
      cib_host_i.start();
      tx({a, 1'b1}, 1'b0);
      cib_host_i.stop();
   endtask
   // Read n bytes from k; all ones past the group end
   task automatic rdg(input int k, input int n);
      cib_host_i.start();
      tx({DEV_ADDR, 1'b1}, 1'b1);
      for (int i = 0; i < n; i++) rx(k + i < glen ? g[k + i] : 8'hFF, i == n - 1);
      cib_host_i.stop();
   endtask
   task automatic word(input logic [7:0] w);
      cib_host_i.start();
      tx({DEV_ADDR, 1'b0}, 1'b1);
      tx(w, 1'b1);
      cib_host_i.stop();
   endtask
   // Command page c[k..k+n-1]; bytes past the size are refused
   task automatic wrf(input int k, input int n);
      cib_host_i.start();
      tx({DEV_ADDR, 1'b0}, 1'b1);
      tx(8'h03, 1'b1);
      for (int i = k; i < k + n; i++) tx(c[i], i < c[0]);
      cib_host_i.stop();
   endtask
   task automatic wake();
      @(posedge CLOCK);
      #1 WAKE = 1'b1;
      repeat (5) @(posedge CLOCK);
      #1 WAKE = 1'b0;
      repeat (5) @(posedge CLOCK);
   endtask
   task automatic stat();
      g[0] = 8'h04;
      g[1] = 8'h11;
      g[2] = CLO;
      g[3] = CHI;
      glen = 4;
   endtask
   // Engine: read the command back, then post a group of len bytes
   task automatic eng(input int n, input int len);
      for (int i = 0; i <= n; i++) begin
         @(posedge CLOCK);
         #1;
         if (i > 0) chk(BUF_RDATA, c[i - 1]);
         BUF_ADDR = (i < n) ? 7'(i) : 7'h50;
      end
      glen = len;
      for (int i = 0; i < len; i++) begin
         g[i] = i == 0 ? 8'(len) : 8'($urandom());
         @(posedge CLOCK);
         #1;
         chk(BUF_RDATA, 8'hFF);
         RES_WE = 1'b1;
         RES_ADDR = 7'(i);
         RES_DATA = g[i];
      end
      @(posedge CLOCK);
      #1;
      RES_WE = 1'b0;
      EXEC_DONE = 1'b1;
      RES_LEN = 7'(len);
      @(posedge CLOCK);
      #1;
      EXEC_DONE = 1'b0;
      chk({7'h00, BUSY}, 8'h00);
   endtask
   task automatic tally_and_finish();
      if (bad_count == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      void'($urandom(16));
      {RST, WAKE, EXEC_DONE, RES_WE, RES_LEN, RES_ADDR, RES_DATA, BUF_ADDR} = 33'h100000000;
      // All ones would match the resync clocking pattern
      DEV_ADDR = 7'($urandom() % 127);
      repeat (4) @(posedge CLOCK);
      #1 RST = 1'b0;
      rdn(DEV_ADDR);
      wake();
      stat();
      rdg(0, 2);
      rdg(2, 3);
      rdg(5, 1);
      word(8'h00);
      rdg(0, 1);
      rdn(DEV_ADDR ^ 7'h01);
      c[0] = 8'h05;
      c[1] = 8'($urandom());
      wrf(0, 2);
      // Partial command: address taken, every data byte all ones
      glen = 0;
      rdg(0, 2);
      word(8'h00);
      for (int it = 0; it < 2; it++) begin
         c[0] = it == 0 ? 8'h04 : 8'h07;
         for (int i = 1; i < 71; i++) c[i] = 8'($urandom());
         m = nst;
         // Last page carries one byte past the size, before Stop makes the port busy
         for (int k = 0; k < c[0]; k += it * 3 + 1)
            wrf(k, k + it * 3 + 1 < c[0] ? it * 3 + 1 : c[0] + 1 - k);
         rdn(DEV_ADDR);
         chk(8'(nst - m), 8'h01);
         eng(c[0], it == 0 ? 4 : 4 + $urandom() % 32);
         rdg(0, glen + 1);
      end
      word(8'h02);
      #40 chk({7'h00, IDLE}, 8'h01);
      rdn(DEV_ADDR);
      wake();
      word(8'h00);
      rdg(0, 1);
      word(8'h00);
      cib_host_i.start();
      tx({DEV_ADDR, 1'b1}, 1'b1);
      #50 chk({7'h00, SDA_OE}, 8'h01);
      chk({7'h00, SDA_OUT}, 8'h00);
      repeat (TM + 20) @(posedge CLOCK);
      #1 chk({7'h00, SDA_OE}, 8'h00);
      cib_host_i.resync();
      word(8'h00);
      rdg(0, 1);
      word(8'h01);
      #40 chk({7'h00, ASLEEP}, 8'h01);
      rdn(DEV_ADDR);
      wake();
      stat();
      rdg(0, 4);
      repeat (WD + 100) @(posedge CLOCK);
      #1 chk({7'h00, ASLEEP}, 8'h01);
      rdn(DEV_ADDR);
      tally_and_finish();
   end
endmodule // testbench
